// *** imv_pkg.sv ***
package imv_pkg;
    // register byte addresses
    localparam logic [31:0] IFR_ADDR = 32'h8000_0028;
    localparam logic [31:0] PSR_ADDR = 32'h8000_0030;
    localparam logic [31:0] VAB_ADDR = 32'h8000_0034;
    localparam logic [31:0] PCOND_ADDR = 32'h8000_0038;
    localparam logic [31:0] PMASK_ADDR = 32'h8000_003C;
    localparam logic [31:0] PIRQ_ADDR = 32'h8000_0040;
    // processor status fields
    localparam int PSR_IP = 14;
    localparam int PSR_WM = 7;
    localparam int PSR_SM = 4;
    localparam int PSR_IM = 2;
    localparam int PSR_DI = 1;
    localparam int PSR_DA = 0;
    // interrupt flag fields, vector base lsb and device-init condition bit
    localparam int IFR_VIDEO = 27;
    localparam int IFR_PIN = 16;
    localparam int IFR_DMA0 = 14;
    localparam int IFR_DMA1 = 13;
    localparam int IFR_XFER = 12;
    localparam int IFR_CTRL = 11;
    localparam int IFR_RXS = 7;
    localparam int IFR_RXD = 6;
    localparam int IFR_TXE = 5;
    localparam int VAB_LSB = 10;
    localparam int COND_DEVINIT = 1;
    // reset values
    localparam logic [1:0] IM_RST = 2'h0;
    localparam logic SM_RST = 1'b1;
    localparam logic DI_RST = 1'b1;
    localparam logic DA_RST = 1'b1;
    localparam logic [21:0] VAB_RST = 22'h00_0000;
    // vector numbers
    localparam logic [7:0] VEC_WITHDRAWN = 8'h00;
    localparam logic [7:0] VEC_PROT = 8'h05;
    localparam logic [7:0] VEC_PERIPH = 8'h06;
    localparam logic [7:0] VEC_TIMER = 8'h0E;
    localparam logic [7:0] VEC_TRACE = 8'h0F;
    localparam logic [7:0] VEC_LINE0 = 8'h10;
    localparam logic [7:0] VEC_LINE2 = 8'h12;
    localparam logic [7:0] VEC_INTERNAL = 8'h13;

    typedef enum logic {ST_IDLE, ST_ACK} imv_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } imv_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } imv_apb_rsp_s;

    typedef struct packed {
        logic video;
        logic [7:0] pin;
        logic dma0;
        logic dma1;
        logic rxs;
        logic rxd;
        logic txe;
    } imv_src_s;

    typedef struct packed {
        imv_state_e st;
        logic line2;
        logic wm;
        logic sm;
        logic [1:0] im;
        logic di;
        logic da;
        logic [21:0] vab;
        logic xfer;
        logic ctrl;
        logic [15:0] cond;
        logic [15:0] pmask;
        logic bad_pend;
        logic take;
        logic [7:0] vec;
        logic [31:0] rdata;
        logic slverr;
    } imv_state_s;
endpackage

// *** imv_gate.sv ***
`timescale 1ns/100ps
module imv_gate
    import imv_pkg::*;
(
    input wire logic [1:0] im_i,
    input wire logic di_i,
    input wire logic da_i,
    input wire logic line0_i,
    input wire logic line2_i,
    input wire logic internal_i,
    input wire logic timer_i,
    input wire logic trace_i,
    output logic en_line0_o,
    output logic en_line2_o,
    output logic en_int_o,
    output logic en_timer_o,
    output logic en_trace_o,
    output logic irq_pending_flag_o
);
    logic open_irq;

    // line 0 is never masked by the mask field
    assign open_irq = !di_i && !da_i;
    assign en_line0_o = line0_i && open_irq;
    assign en_line2_o = line2_i && open_irq && im_i[1];
    assign en_int_o = internal_i && open_irq && (im_i == 2'h3);
    // timer and trace survive the interrupt block, not the all block
    assign en_timer_o = timer_i && !da_i;
    assign en_trace_o = trace_i && !da_i;
    assign irq_pending_flag_o =
        (line0_i && !en_line0_o) || (line2_i && !en_line2_o) ||
        (internal_i && !en_int_o) || (timer_i && !en_timer_o);
endmodule

// *** imv_core.sv ***
`timescale 1ns/100ps
// Overview of operation
// - wait bit set stalls the processor until woken
// - taking an enabled interrupt or trap, or reset, clears wait
// - supervisor bit one allows all context, zero means user mode
// - user-mode access to protected context raises protection trap
// - mask field: line 0 always, 10 adds line 2, 11 adds internal
// - interrupt block drops line 0, line 2, internal; keeps traps, timer
// - all-block bit set takes no interrupts and only protection and peripheral traps
// - all-block clear takes every trap; interrupts per mask and block
// - video flag shows pending video request
// - eight pin flags, top bit is pin 15
// - separate flags for dma channel 0 and channel 1
// - parallel transfer flag reads one while transfer requested
// - write one or data register access clears transfer request
// - control flag set by each new masked condition event, then held
// - control flag cleared by its own write, not by causes
// - write one to condition or irq status bit clears condition
// - device-init condition clears only on return to compat mode
// - three serial flags: rx status, rx data, tx empty
// - taken event yields 8-bit vector, fixed or from instruction
// - entry address puts vector into bits 9 to 2 of base
// - unsupported peripheral address raises trap vector 6
// - external line withdrawn before taken gives vector 0
// - pending bit set while request active but blocked
module imv_core
    import imv_pkg::*;
#(
    parameter int COND_W = 10
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire imv_apb_req_s apb_req_i,
    output imv_apb_rsp_s apb_rsp_o,
    input wire imv_src_s src_i,
    input wire logic ext_irq_line_0_i,
    input wire logic ext_irq_line_2_i,
    input wire logic timer_irq_i,
    input wire logic trace_trap_i,
    input wire logic trap_req_i,
    input wire logic [7:0] trap_vec_i,
    input wire logic protected_access_i,
    input wire logic pport_xfer_req_i,
    input wire logic pport_data_access_i,
    input wire logic [COND_W-1:0] pport_cond_event_i,
    input wire logic pport_compat_mode_i,
    output logic take_o,
    output logic [7:0] vector_o,
    output logic [31:0] vector_addr_o,
    output logic core_stall_o,
    output logic supervisor_o
);
    if (COND_W < 2 || COND_W > 16) begin : g_chk
        $error("COND_W must be 2 to 16");
    end

    imv_state_s s_q;
    imv_state_s s_d;
    logic [31:0] ifr;
    logic [31:0] psr;
    logic [15:0] cond_irq;
    logic [15:0] ev;
    logic internal_req;
    logic en_l0;
    logic en_l2;
    logic en_int;
    logic en_tmr;
    logic en_trc;
    logic ip;
    logic setup;
    logic wr;
    logic hit;
    logic prot;

    ////////////////////////////////////////////////////////////////////
    assign ev = 16'(pport_cond_event_i);
    assign cond_irq = s_q.cond & s_q.pmask;

    always_comb begin
        ifr = 32'h0000_0000;
        ifr[IFR_VIDEO] = src_i.video;
        ifr[IFR_PIN+:8] = src_i.pin;
        ifr[IFR_DMA0] = src_i.dma0;
        ifr[IFR_DMA1] = src_i.dma1;
        ifr[IFR_XFER] = s_q.xfer;
        ifr[IFR_CTRL] = s_q.ctrl;
        ifr[IFR_RXS] = src_i.rxs;
        ifr[IFR_RXD] = src_i.rxd;
        ifr[IFR_TXE] = src_i.txe;
    end

    assign internal_req = |ifr;

    imv_gate u_gate (
        .im_i(s_q.im),
        .di_i(s_q.di),
        .da_i(s_q.da),
        .line0_i(ext_irq_line_0_i),
        .line2_i(ext_irq_line_2_i),
        .internal_i(internal_req),
        .timer_i(timer_irq_i),
        .trace_i(trace_trap_i),
        .en_line0_o(en_l0),
        .en_line2_o(en_l2),
        .en_int_o(en_int),
        .en_timer_o(en_tmr),
        .en_trace_o(en_trc),
        .irq_pending_flag_o(ip)
    );

    always_comb begin
        psr = 32'h0000_0000;
        psr[PSR_IP] = ip;
        psr[PSR_WM] = s_q.wm;
        psr[PSR_SM] = s_q.sm;
        psr[PSR_IM+:2] = s_q.im;
        psr[PSR_DI] = s_q.di;
        psr[PSR_DA] = s_q.da;
    end

    assign setup = apb_req_i.psel && !apb_req_i.penable;
    assign wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
    assign hit = apb_req_i.paddr == IFR_ADDR || apb_req_i.paddr == PSR_ADDR
        || apb_req_i.paddr == VAB_ADDR || apb_req_i.paddr == PCOND_ADDR
        || apb_req_i.paddr == PMASK_ADDR || apb_req_i.paddr == PIRQ_ADDR;
    assign prot = protected_access_i && !s_q.sm;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.take = 1'b0;
        // read data and error captured in the setup cycle, zero wait
        if (setup) begin
            s_d.slverr = !hit;
            if (apb_req_i.paddr == IFR_ADDR) begin
                s_d.rdata = ifr;
            end else if (apb_req_i.paddr == PSR_ADDR) begin
                s_d.rdata = psr;
            end else if (apb_req_i.paddr == VAB_ADDR) begin
                s_d.rdata = {s_q.vab, 10'h000};
            end else if (apb_req_i.paddr == PCOND_ADDR) begin
                s_d.rdata = {16'h0000, s_q.cond};
            end else if (apb_req_i.paddr == PMASK_ADDR) begin
                s_d.rdata = {16'h0000, s_q.pmask};
            end else if (apb_req_i.paddr == PIRQ_ADDR) begin
                s_d.rdata = {16'h0000, cond_irq};
            end else begin
                s_d.rdata = 32'h0000_0000;
                s_d.bad_pend = 1'b1;
            end
        end
        // register writes; hardware sets below override the clears
        if (wr) begin
            if (apb_req_i.paddr == PSR_ADDR) begin
                s_d.wm = apb_req_i.pwdata[PSR_WM];
                s_d.sm = apb_req_i.pwdata[PSR_SM];
                s_d.im = apb_req_i.pwdata[PSR_IM+:2];
                s_d.di = apb_req_i.pwdata[PSR_DI];
                s_d.da = apb_req_i.pwdata[PSR_DA];
            end else if (apb_req_i.paddr == VAB_ADDR) begin
                s_d.vab = apb_req_i.pwdata[31:VAB_LSB];
            end else if (apb_req_i.paddr == PMASK_ADDR) begin
                s_d.pmask = 16'(apb_req_i.pwdata[COND_W-1:0]);
            end else if (apb_req_i.paddr == IFR_ADDR) begin
                if (apb_req_i.pwdata[IFR_XFER]) begin
                    s_d.xfer = 1'b0;
                end
                if (apb_req_i.pwdata[IFR_CTRL]) begin
                    s_d.ctrl = 1'b0;
                end
            end else if (apb_req_i.paddr == PCOND_ADDR) begin
                s_d.cond = s_q.cond & ~apb_req_i.pwdata[15:0];
            end else if (apb_req_i.paddr == PIRQ_ADDR) begin
                s_d.cond = s_q.cond & ~(apb_req_i.pwdata[15:0]
                    & s_q.pmask);
            end
        end
        // device-init is immune to writes
        s_d.cond[COND_DEVINIT] = s_q.cond[COND_DEVINIT]
            && !pport_compat_mode_i;
        s_d.cond = s_d.cond | ev;
        if (pport_data_access_i) begin
            s_d.xfer = 1'b0;
        end
        if (pport_xfer_req_i) begin
            s_d.xfer = 1'b1;
        end
        // sticky; new masked causes set it, cleared only by its own write
        if (|(ev & s_q.pmask)) begin
            s_d.ctrl = 1'b1;
        end
        ////////////////////////////////////////////////////////////////
        case (s_q.st)
            ST_IDLE: begin
                if (prot) begin
                    s_d.take = 1'b1;
                    s_d.vec = VEC_PROT;
                end else if (s_q.bad_pend) begin
                    s_d.take = 1'b1;
                    s_d.vec = VEC_PERIPH;
                    s_d.bad_pend = 1'b0;
                end else if (trap_req_i && !s_q.da) begin
                    s_d.take = 1'b1;
                    s_d.vec = trap_vec_i;
                end else if (en_trc) begin
                    s_d.take = 1'b1;
                    s_d.vec = VEC_TRACE;
                end else if (en_tmr) begin
                    s_d.take = 1'b1;
                    s_d.vec = VEC_TIMER;
                end else if (en_l0 || en_l2) begin
                    // one acknowledge cycle, line sampled again there
                    s_d.st = ST_ACK;
                    s_d.line2 = !en_l0;
                end else if (en_int) begin
                    s_d.take = 1'b1;
                    s_d.vec = VEC_INTERNAL;
                end
            end
            ST_ACK: begin
                s_d.st = ST_IDLE;
                s_d.take = 1'b1;
                if (s_q.line2) begin
                    s_d.vec = ext_irq_line_2_i ? VEC_LINE2
                        : VEC_WITHDRAWN;
                end else begin
                    s_d.vec = ext_irq_line_0_i ? VEC_LINE0
                        : VEC_WITHDRAWN;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        // handler runs supervised with the all-block bit set
        if (s_d.take) begin
            s_d.wm = 1'b0;
            s_d.sm = 1'b1;
            s_d.da = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.sm <= SM_RST;
            s_q.im <= IM_RST;
            s_q.di <= DI_RST;
            s_q.da <= DA_RST;
            s_q.vab <= VAB_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign take_o = s_q.take;
    assign vector_o = s_q.vec;
    assign vector_addr_o = {s_q.vab, s_q.vec, 2'b00};
    assign core_stall_o = s_q.wm;
    assign supervisor_o = s_q.sm;
    assign apb_rsp_o.prdata = s_q.rdata;
    assign apb_rsp_o.pready = 1'b1;
    assign apb_rsp_o.pslverr = s_q.slverr;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_stalled;
        core_stall_o && !take_o;
    endsequence
    sequence s_wake;
        take_o ##1 !core_stall_o;
    endsequence
    property p_wait_holds;
        s_stalled ##0 (!s_d.take) |=> core_stall_o;
    endproperty
    a_wait_holds: assert property (p_wait_holds)
        else $error("wait bit dropped without a take");
    property p_wake;
        s_d.take |=> s_wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wait bit survived a take");
    property p_prot;
        (prot && s_q.st == ST_IDLE) |=> take_o && vector_o == VEC_PROT;
    endproperty
    a_prot: assert property (p_prot)
        else $error("user access to protected context not trapped");
    property p_line2_mask;
        (s_q.st == ST_IDLE && s_d.st == ST_ACK && s_d.line2)
            |-> s_q.im[1] && !s_q.di && !s_q.da;
    endproperty
    a_line2_mask: assert property (p_line2_mask)
        else $error("line 2 accepted while masked");
    property p_da_blocks;
        (take_o && vector_o >= VEC_LINE0 && vector_o <= VEC_INTERNAL)
            |-> ($past(s_q.st == ST_ACK, 1) ? !$past(s_q.da, 2)
            : !$past(s_q.da, 1));
    endproperty
    a_da_blocks: assert property (p_da_blocks)
        else $error("interrupt taken while all-block set");
    property p_xfer_clear;
        (wr && apb_req_i.paddr == IFR_ADDR && apb_req_i.pwdata[IFR_XFER]
            && !pport_xfer_req_i) |=> !ifr[IFR_XFER];
    endproperty
    a_xfer_clear: assert property (p_xfer_clear)
        else $error("transfer flag not cleared by write one");
    property p_ctrl_keep;
        (s_q.ctrl && wr && apb_req_i.paddr == PCOND_ADDR) |=> s_q.ctrl;
    endproperty
    a_ctrl_keep: assert property (p_ctrl_keep)
        else $error("control flag cleared by clearing a cause");
    property p_devinit;
        (s_q.cond[COND_DEVINIT] && !pport_compat_mode_i)
            |=> s_q.cond[COND_DEVINIT];
    endproperty
    a_devinit: assert property (p_devinit)
        else $error("device-init condition lost outside compat mode");
    property p_vaddr;
        take_o |-> vector_addr_o[9:2] == vector_o
            && vector_addr_o[31:10] == s_q.vab;
    endproperty
    a_vaddr: assert property (p_vaddr)
        else $error("vector address malformed");
    property p_periph;
        (setup && !hit && !prot) ##1 (!prot)[*2]
            |-> take_o && vector_o == VEC_PERIPH;
    endproperty
    a_periph: assert property (p_periph)
        else $error("unsupported address not trapped with vector 6");
    property p_withdraw;
        (s_q.st == ST_ACK && !s_q.line2 && !ext_irq_line_0_i)
            |=> take_o && vector_o == VEC_WITHDRAWN;
    endproperty
    a_withdraw: assert property (p_withdraw)
        else $error("withdrawn line did not give vector 0");
endmodule

// *** imv_src_model.sv ***
`timescale 1ns/100ps
module imv_src_model
    import imv_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [5:0] set_i,
    input wire logic drop_i,
    input wire logic [7:0] vec_in_i,
    input wire logic take_i,
    input wire logic [7:0] vector_i,
    output logic [5:0] req_o = 6'h00,
    output logic [7:0] trap_vec_o = 8'h00
);
    ////////////////////////////////////////////////////////////////////////
    // levels: line0, line2, timer, trap, protected, trace; held until taken
    always @(posedge clk_sys_i) begin
        if (rst_i || drop_i) begin
            req_o <= 6'h00;
        end else begin
            req_o <= req_o | set_i;
            if (take_i) begin
                case (vector_i)
                    VEC_LINE0: req_o[0] <= 1'b0;
                    VEC_LINE2: req_o[1] <= 1'b0;
                    VEC_TIMER: req_o[2] <= 1'b0;
                    VEC_PROT: req_o[4] <= 1'b0;
                    VEC_TRACE: req_o[5] <= 1'b0;
                    default: if (vector_i >= 8'h40) req_o[3] <= 1'b0;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // released vector lines toggle so a stale value cannot pass
    always @(posedge clk_sys_i) begin
        if (set_i[3]) begin
            trap_vec_o <= vec_in_i;
        end else if (!req_o[3]) begin
            trap_vec_o <= ~trap_vec_o;
        end
    end
endmodule

// *** test_interrupt_mask_and_vectoring.sv ***
`timescale 1ns/100ps
module test_interrupt_mask_and_vectoring
    import imv_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    imv_apb_req_s req = '0;
    imv_apb_rsp_s rsp;
    imv_src_s src = '0;
    logic [5:0] ev_set = '0;
    logic drop = 1'b0;
    logic [7:0] tv_in = '0;
    logic [5:0] lv;
    logic [7:0] tv;
    logic [12:0] pin = '0;
    logic take, stall, sup;
    logic [7:0] vec;
    logic [31:0] vaddr;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int expq[$];
    logic [31:0] vab_m = '0;
    logic [31:0] seed = 32'h0000_86AF;
    // blocked-or-taken table: status value, source kind, vector (-1 none)
    // kinds: 0..5 model levels (5 trace), 6 internal dma1 flag
    logic [7:0] tp[12] = '{8'h10, 8'h18, 8'h18, 8'h1C, 8'h14, 8'h1E,
                           8'h1E, 8'h1D, 8'h1D, 8'h90, 8'h1E, 8'h1D};
    int tk[12] = '{1, 1, 6, 6, 0, 0, 2, 2, 1, 0, 5, 3};
    int tx[12] = '{-1, 18, -1, 19, 16, -1, 14, -1, -1, 16, 15, -1};

    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    imv_core #(.COND_W(10)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .apb_req_i(req), .apb_rsp_o(rsp), .src_i(src),
        .ext_irq_line_0_i(lv[0]), .ext_irq_line_2_i(lv[1]),
        .timer_irq_i(lv[2]), .trace_trap_i(lv[5]),
        .trap_req_i(lv[3]), .trap_vec_i(tv), .protected_access_i(lv[4]),
        .pport_xfer_req_i(pin[10]), .pport_data_access_i(pin[11]),
        .pport_cond_event_i(pin[9:0]), .pport_compat_mode_i(pin[12]),
        .take_o(take), .vector_o(vec), .vector_addr_o(vaddr),
        .core_stall_o(stall), .supervisor_o(sup)
    );

    imv_src_model far (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .set_i(ev_set),
        .drop_i(drop), .vec_in_i(tv_in), .take_i(take),
        .vector_i(vec), .req_o(lv), .trap_vec_o(tv)
    );

    ////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic close_out();
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_sys_i);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys_i);
        req.penable <= 1'b1;
        // request held until pready is seen high at a rising edge
        do begin
            @(posedge clk_sys_i);
        end while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [31:0] a, x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, x);
    endtask

    task automatic ev(input int k);
        @(posedge clk_sys_i);
        ev_set[k] <= 1'b1;
        @(posedge clk_sys_i);
        ev_set <= '0;
    endtask

    task automatic dr();
        @(posedge clk_sys_i);
        drop <= 1'b1;
        src <= '0;
        @(posedge clk_sys_i);
        drop <= 1'b0;
    endtask

    task automatic pp(input logic [12:0] p);
        @(posedge clk_sys_i);
        pin <= p;
        @(posedge clk_sys_i);
        pin <= '0;
    endtask

    // bounded wait for every queued take to be seen
    task automatic wait_q();
        for (int i = 0; i < 20 && expq.size() != 0; i++) begin
            @(posedge clk_sys_i);
        end
        chk(expq.size(), 0);
    endtask

    function automatic logic [31:0] ifr(input logic [13:0] s);
        return {4'h0, s[13], 3'h0, s[12:5], 1'b0, s[4:3], 5'h00,
                s[2:0], 5'h00};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // take_o stands one cycle; sampled mid-cycle where it is settled
    always @(negedge clk_sys_i) begin
        int x;
        if (!rst_i && take === 1'b1) begin
            x = (expq.size() != 0) ? expq.pop_front() : -1;
            chk({24'h00_0000, vec}, x);
            chk(vaddr, {vab_m[31:10], x[7:0], 2'b00});
        end
    end

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        logic [31:0] r;
        logic e;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(PSR_ADDR, 32'h0000_0013);
        repeat (4) begin
            r = rnd();
            src <= imv_src_s'(r[13:0]);
            rd(IFR_ADDR, ifr(r[13:0]));
        end
        src <= '0;
        expq.push_back(VEC_PERIPH);
        apb(1'b0, 32'h8000_0044, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        wait_q();
        r = rnd();
        wr(VAB_ADDR, r);
        vab_m = r & 32'hFFFF_FC00;
        rd(VAB_ADDR, vab_m);
        wr(PSR_ADDR, 32'h0000_0010);
        r = rnd();
        tv_in <= r[7:0] | 8'h40;
        expq.push_back(r[7:0] | 8'h40);
        ev(3);
        wait_q();
        for (int i = 0; i < 12; i++) begin
            wr(PSR_ADDR, {24'h00_0000, tp[i]});
            @(negedge clk_sys_i);
            chk({31'h0, stall}, {31'h0, tp[i][7]});
            if (tx[i] >= 0) expq.push_back(tx[i]);
            if (tk[i] == 6) begin
                @(posedge clk_sys_i);
                src.dma1 <= 1'b1;
            end else begin
                ev(tk[i]);
            end
            wait_q();
            // traps never count as pending interrupts
            if (tx[i] < 0 && tk[i] != 3 && tk[i] != 5) begin
                repeat (3) @(posedge clk_sys_i);
                rd(PSR_ADDR, {24'h00_0000, tp[i]} | 32'h0000_4000);
            end
            @(negedge clk_sys_i);
            chk({31'h0, stall}, 32'h0000_0000);
            dr();
            if (tx[i] < 0) rd(PSR_ADDR, {24'h00_0000, tp[i]});
        end
        wr(PSR_ADDR, 32'h0000_0011);
        ev(4);
        repeat (4) @(posedge clk_sys_i);
        dr();
        wr(PSR_ADDR, 32'h0000_0001);
        @(negedge clk_sys_i);
        chk({31'h0, sup}, 32'h0000_0000);
        expq.push_back(VEC_PROT);
        ev(4);
        wait_q();
        wr(PSR_ADDR, 32'h0000_0010);
        expq.push_back(VEC_WITHDRAWN);
        ev(0);
        drop <= 1'b1;
        @(posedge clk_sys_i);
        drop <= 1'b0;
        wait_q();
        pp(13'h0400);
        rd(IFR_ADDR, 32'h0000_1000);
        wr(IFR_ADDR, 32'h0000_1000);
        rd(IFR_ADDR, 32'h0000_0000);
        pp(13'h0400);
        pp(13'h0800);
        rd(IFR_ADDR, 32'h0000_0000);
        wr(PMASK_ADDR, 32'h0000_03FF);
        pp(13'h0008);
        rd(PIRQ_ADDR, 32'h0000_0008);
        rd(IFR_ADDR, 32'h0000_0800);
        wr(PCOND_ADDR, 32'h0000_0008);
        rd(PCOND_ADDR, 32'h0000_0000);
        rd(IFR_ADDR, 32'h0000_0800);
        wr(IFR_ADDR, 32'h0000_0800);
        rd(IFR_ADDR, 32'h0000_0000);
        pp(13'h0022);
        wr(PIRQ_ADDR, 32'h0000_0022);
        rd(PCOND_ADDR, 32'h0000_0002);
        pp(13'h1000);
        rd(PCOND_ADDR, 32'h0000_0000);
        chk(expq.size(), 0);
        close_out();
    end
endmodule
